// file: lss_handler.sv
// Purpose: Limit switch detection, stop control, event lock and position capture
// Assumes: Register port strobes are synchronous single-cycle pulses
// Notes:   Ramp generator outside obeys the halt and lock outputs
`timescale 1ns/1ps

// Notes on behaviour
// - Left switch enabled, at its polarity, velocity negative: stop the ramp.
// - Right switch enabled, at its polarity, velocity positive: stop the ramp.
// - Soft stop off: active enabled switch forces velocity to zero at once.
// - Soft stop on: linear deceleration at the stop rate; halt velocity ignored.
// - Stop status flag follows an enabled active switch, clears when inactive.
// - Enabled switch becoming active sets a sticky event until software clears.
// - After velocity reaches zero, motion toward the switch is blocked while event set.
// - Events read clears event and releases lock if switch inactive or disabled.
// - Position captured on four selectable switch transitions, each enabled separately.
// - Polarity zero: inactive on rising, active on falling; polarity one reversed.
// - Swap bit exchanges left and right inputs; enables and polarities stay with the left and right roles.
// - Virtual stop when position at or below low limit or at or above high.
// - Target reached output whenever present position equals goal position.
module lss_handler
  import lss_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              left_limit_in,
  input  wire logic              right_limit_in,
  input  wire logic signed [31:0] present_velocity,
  input  wire logic signed [31:0] present_position,
  input  wire logic signed [31:0] goal_position,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  output logic                   halt_hard,
  output logic                   halt_soft,
  output logic      [31:0]       halt_decel_rate,
  output logic                   lock_neg,
  output logic                   lock_pos,
  output logic                   target_reached
);

  logic [13:0]         cfg_ff;
  logic [31:0]         margin_ff;
  logic [31:0]         decel_ff;
  logic [31:0]         compare_ff;
  logic signed [31:0]  low_ff;
  logic signed [31:0]  high_ff;
  logic [31:0]         origin_ff;
  logic [31:0]         capture_ff;
  logic [4:0]          status_ff;
  logic [4:0]          event_ff;
  logic [4:0]          nxt_event;
  logic [31:0]         rdata_ff;
  logic                rvalid_ff;
  logic                halt_hard_ff;
  logic                halt_soft_ff;
  logic [31:0]         decel_out_ff;
  logic                lock_neg_ff;
  logic                lock_pos_ff;
  logic                target_ff;
  logic [1:0]          sw_sync;
  logic                eff_left_ff;
  logic                eff_right_ff;
  logic                eff_left;
  logic                eff_right;
  logic                act_l;
  logic                act_r;
  logic                prev_act_l;
  logic                prev_act_r;
  logic                vact_l;
  logic                vact_r;
  logic                vel_neg;
  logic                vel_pos;
  logic                vel_zero;
  logic                hw_stop;
  logic                v_stop;
  logic                v_linear;
  logic                cap_hit;
  logic                ev_read;
  logic [4:0]          active_now;
  logic [4:0]          rise_now;

  lss_sync #(
    .W      (2),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_in    ({right_limit_in, left_limit_in}),
    .q_out   (sw_sync)
  );

  // Role swap of the two inputs
  assign eff_left  = cfg_ff[CFG_SWAP] ? sw_sync[1] : sw_sync[0];
  assign eff_right = cfg_ff[CFG_SWAP] ? sw_sync[0] : sw_sync[1];

  // Switch active at programmed level and enabled
  assign act_l = cfg_ff[CFG_LEFT_EN] & (eff_left == cfg_ff[CFG_POL_LEFT]);
  assign act_r = cfg_ff[CFG_RIGHT_EN] & (eff_right == cfg_ff[CFG_POL_RIGHT]);
  assign prev_act_l = (eff_left_ff == cfg_ff[CFG_POL_LEFT]);
  assign prev_act_r = (eff_right_ff == cfg_ff[CFG_POL_RIGHT]);

  // Virtual limits on signed position
  assign vact_l = cfg_ff[CFG_VIRT_L_EN] & (present_position <= low_ff);
  assign vact_r = cfg_ff[CFG_VIRT_R_EN] & (present_position >= high_ff);

  assign vel_neg  = present_velocity < 0;
  assign vel_pos  = present_velocity > 0;
  assign vel_zero = present_velocity == 0;

  assign hw_stop  = (act_l & vel_neg) | (act_r & vel_pos);
  assign v_stop   = (vact_l & vel_neg) | (vact_r & vel_pos);
  assign v_linear = cfg_ff[CFG_VMODE_LO+1 -: 2] == VMODE_LINEAR;

  // Capture transitions relative to polarity
  assign cap_hit =
      (cfg_ff[CFG_LATCH_IN_L] & prev_act_l & ~(eff_left == cfg_ff[CFG_POL_LEFT]))
    | (cfg_ff[CFG_LATCH_AC_L] & ~prev_act_l & (eff_left == cfg_ff[CFG_POL_LEFT]))
    | (cfg_ff[CFG_LATCH_IN_R] & prev_act_r & ~(eff_right == cfg_ff[CFG_POL_RIGHT]))
    | (cfg_ff[CFG_LATCH_AC_R] & ~prev_act_r & (eff_right == cfg_ff[CFG_POL_RIGHT]));

  assign ev_read    = reg_rd & (reg_addr == ADR_EVENTS);
  assign active_now = {1'b0, vact_r, vact_l, act_r, act_l};
  assign rise_now   = active_now & ~status_ff;

  // Previous effective levels for edges
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      eff_left_ff  <= 1'b0;
      eff_right_ff <= 1'b0;
    end
    else
    begin
      eff_left_ff  <= eff_left;
      eff_right_ff <= eff_right;
    end
  end

  // Configuration and limit registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_ff     <= RST_CFG;
      margin_ff  <= RST_WORD;
      decel_ff   <= RST_WORD;
      compare_ff <= RST_WORD;
      low_ff     <= RST_WORD;
      high_ff    <= RST_WORD;
      origin_ff  <= RST_WORD;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADR_SWITCH_CFG:  cfg_ff     <= reg_wdata[CFG_USED_W-1:0];
        ADR_HOME_MARGIN: margin_ff  <= reg_wdata;
        ADR_HALT_DECEL:  decel_ff   <= reg_wdata;
        ADR_COMPARE_POS: compare_ff <= reg_wdata;
        ADR_SOFT_LOW:    low_ff     <= reg_wdata;
        ADR_SOFT_HIGH:   high_ff    <= reg_wdata;
        ADR_ORIGIN_POS:  origin_ff  <= reg_wdata;
        default:         cfg_ff     <= cfg_ff;
      endcase
    end
  end

  // Captured position, hardware capture wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      capture_ff <= RST_WORD;
    else if (cap_hit)
      capture_ff <= present_position;
    else if (reg_wr && reg_addr == ADR_CAPTURE_POS)
      capture_ff <= reg_wdata;
  end

  // Live status flags
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      status_ff <= RST_FLAGS;
    else
      status_ff <= {present_position == goal_position, active_now[3:0]};
  end

  // Sticky events; new event wins over read clear
  always_comb
  begin
    nxt_event = event_ff;
    if (ev_read)
      nxt_event = event_ff & active_now;
    nxt_event = nxt_event | rise_now;
    if (cap_hit)
      nxt_event[EV_LATCH] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      event_ff <= RST_FLAGS;
    else
      event_ff <= nxt_event;
  end

  // Stop outputs to the ramp generator
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      halt_hard_ff <= 1'b0;
      halt_soft_ff <= 1'b0;
      decel_out_ff <= RST_WORD;
    end
    else
    begin
      halt_hard_ff <= (hw_stop & ~cfg_ff[CFG_SOFT_STOP]) | (v_stop & ~v_linear);
      halt_soft_ff <= (hw_stop & cfg_ff[CFG_SOFT_STOP]) | (v_stop & v_linear);
      decel_out_ff <= decel_ff;
    end
  end

  // Direction locks after standstill
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lock_neg_ff <= 1'b0;
      lock_pos_ff <= 1'b0;
    end
    else
    begin
      lock_neg_ff <= (nxt_event[ST_LEFT] | nxt_event[ST_VLEFT])
                     & (lock_neg_ff | vel_zero);
      lock_pos_ff <= (nxt_event[ST_RIGHT] | nxt_event[ST_VRIGHT])
                     & (lock_pos_ff | vel_zero);
    end
  end

  // Target reached pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      target_ff <= 1'b0;
    else
      target_ff <= present_position == goal_position;
  end

  // Register read port
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata_ff  <= RST_WORD;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          ADR_SWITCH_CFG:  rdata_ff <= {18'h00000, cfg_ff};
          ADR_EVENTS:      rdata_ff <= {27'h0000000, event_ff};
          ADR_STATUS:      rdata_ff <= {27'h0000000, status_ff};
          ADR_HOME_MARGIN: rdata_ff <= margin_ff;
          ADR_HALT_DECEL:  rdata_ff <= decel_ff;
          ADR_COMPARE_POS: rdata_ff <= compare_ff;
          ADR_SOFT_LOW:    rdata_ff <= low_ff;
          ADR_SOFT_HIGH:   rdata_ff <= high_ff;
          ADR_ORIGIN_POS:  rdata_ff <= origin_ff;
          ADR_CAPTURE_POS: rdata_ff <= capture_ff;
          default:         rdata_ff <= RST_WORD;
        endcase
      end
    end
  end

  assign reg_rdata       = rdata_ff;
  assign reg_rvalid      = rvalid_ff;
  assign halt_hard       = halt_hard_ff;
  assign halt_soft       = halt_soft_ff;
  assign halt_decel_rate = decel_out_ff;
  assign lock_neg        = lock_neg_ff;
  assign lock_pos        = lock_pos_ff;
  assign target_reached  = target_ff;

  // Checks
  left_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (act_l && vel_neg) |=> (halt_hard_ff || halt_soft_ff))
    else $error("Left stop not raised");

  right_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (act_r && vel_pos) |=> (halt_hard_ff || halt_soft_ff))
    else $error("Right stop not raised");

  hard_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hw_stop && !cfg_ff[CFG_SOFT_STOP]) |=> (halt_hard_ff && (!halt_soft_ff
      || $past(v_stop && v_linear))))
    else $error("Hard stop mode wrong");

  soft_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hw_stop && cfg_ff[CFG_SOFT_STOP]) |=> (halt_soft_ff && decel_out_ff == $past(decel_ff)))
    else $error("Linear stop mode wrong");

  status_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(sw_sync[0] == cfg_ff[CFG_POL_LEFT]) && !cfg_ff[CFG_SWAP] && $stable(cfg_ff)
      |=> !status_ff[ST_LEFT])
    else $error("Status flag not cleared");

  sticky_event_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (event_ff[ST_LEFT] && !ev_read) |=> event_ff[ST_LEFT])
    else $error("Event dropped without read");

  lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lock_neg_ff && !ev_read) |=> lock_neg_ff)
    else $error("Lock released without read");

  read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev_read && event_ff[ST_RIGHT] && !act_r && !event_ff[ST_VRIGHT] && !vact_r)
      |=> (!event_ff[ST_RIGHT] && !lock_pos_ff))
    else $error("Read did not release");

  capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cap_hit |=> (capture_ff == $past(present_position)) && event_ff[EV_LATCH])
    else $error("Capture missed");

  virtual_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg_ff[CFG_VIRT_R_EN] && present_position >= high_ff) |=> status_ff[ST_VRIGHT])
    else $error("Virtual limit flag missing");

  target_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (present_position == goal_position) |=> target_ff)
    else $error("Target reached missing");

endmodule : lss_handler

// file: lss_pkg.sv
// Purpose: Constants for the limit switch stop handler
// Assumes: Byte-wide register index, 32-bit data
// Notes:   Shared by the handler top and its tests
package lss_pkg;

  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;

  // Register indices
  localparam logic [7:0]  ADR_SWITCH_CFG  = 8'h01;
  localparam logic [7:0]  ADR_EVENTS      = 8'h0E;
  localparam logic [7:0]  ADR_STATUS      = 8'h0F;
  localparam logic [7:0]  ADR_HOME_MARGIN = 8'h1E;
  localparam logic [7:0]  ADR_HALT_DECEL  = 8'h2C;
  localparam logic [7:0]  ADR_COMPARE_POS = 8'h32;
  localparam logic [7:0]  ADR_SOFT_LOW    = 8'h33;
  localparam logic [7:0]  ADR_SOFT_HIGH   = 8'h34;
  localparam logic [7:0]  ADR_ORIGIN_POS  = 8'h35;
  localparam logic [7:0]  ADR_CAPTURE_POS = 8'h36;

  // switch_config field positions
  localparam int          CFG_LEFT_EN     = 0;
  localparam int          CFG_RIGHT_EN    = 1;
  localparam int          CFG_POL_LEFT    = 2;
  localparam int          CFG_POL_RIGHT   = 3;
  localparam int          CFG_SWAP        = 4;
  localparam int          CFG_SOFT_STOP   = 5;
  localparam int          CFG_VIRT_L_EN   = 6;
  localparam int          CFG_VIRT_R_EN   = 7;
  localparam int          CFG_VMODE_LO    = 8;
  localparam int          CFG_LATCH_IN_L  = 10;
  localparam int          CFG_LATCH_AC_L  = 11;
  localparam int          CFG_LATCH_IN_R  = 12;
  localparam int          CFG_LATCH_AC_R  = 13;
  localparam int          CFG_USED_W      = 14;

  // Virtual stop slope modes
  localparam logic [1:0]  VMODE_HARD      = 2'h1;
  localparam logic [1:0]  VMODE_LINEAR    = 2'h2;

  // Status and event bit positions
  localparam int          ST_LEFT         = 0;
  localparam int          ST_RIGHT        = 1;
  localparam int          ST_VLEFT        = 2;
  localparam int          ST_VRIGHT       = 3;
  localparam int          ST_TARGET       = 4;
  localparam int          EV_LATCH        = 4;
  localparam int          FLAG_W          = 5;

  // Reset values
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [13:0] RST_CFG         = 14'h0000;
  localparam logic [4:0]  RST_FLAGS       = 5'h00;

  // Limit input synchroniser depth
  localparam int          SYNC_STAGES     = 2;

endpackage : lss_pkg

// file: lss_switch_model.sv
// Purpose: Mechanical limit switch pair beside the handler
// Assumes: Contact state and wiring polarity set by the bench
// Notes:   Pin shows the polarity level while the contact is made
`timescale 1ns/1ps
module lss_switch_model
(
  input  wire logic pol_l,
  input  wire logic pol_r,
  input  wire logic act_l,
  input  wire logic act_r,
  output logic      pin_l,
  output logic      pin_r
);
  // Open contact rests at the inverse level
  assign pin_l = act_l ? pol_l : ~pol_l;
  assign pin_r = act_r ? pol_r : ~pol_r;
endmodule : lss_switch_model

// file: lss_sync.sv
// Purpose: Multi-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow levels, not pulses
// Notes:   Only the last stage may be read outside
`timescale 1ns/1ps
module lss_sync
  import lss_pkg::*;
#(
  parameter int W      = 2,
  parameter int STAGES = SYNC_STAGES
)(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] stage_ff [STAGES];

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++)
    begin : g_stage
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
          stage_ff[gi] <= '0;
        else if (gi == 0)
          stage_ff[gi] <= d_in;
        else
          stage_ff[gi] <= stage_ff[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate

  assign q_out = stage_ff[STAGES-1];

endmodule : lss_sync

// file: tb.sv
// Purpose: Self-checking bench for the limit switch stop handler
// Assumes: Strobe register port, switches through the switch model
// Notes:   Inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module tb;
  import lss_pkg::*;
  logic               clk_sys, rst_n, act_l, act_r, pol_l, pol_r, pin_l, pin_r;
  logic signed [31:0] vel, pos, goal;
  logic               reg_wr, reg_rd, reg_rvalid, halt_hard, halt_soft;
  logic               lock_neg, lock_pos, target_reached;
  logic        [7:0]  reg_addr;
  logic        [31:0] reg_wdata, reg_rdata, halt_decel_rate;
  int                 num_errors, n_compared, cycles;

  lss_switch_model u_sw (.pol_l(pol_l), .pol_r(pol_r), .act_l(act_l), .act_r(act_r),
    .pin_l(pin_l), .pin_r(pin_r));
  lss_handler u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .left_limit_in(pin_l),
    .right_limit_in(pin_r), .present_velocity(vel), .present_position(pos),
    .goal_position(goal), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .halt_hard(halt_hard), .halt_soft(halt_soft), .halt_decel_rate(halt_decel_rate),
    .lock_neg(lock_neg), .lock_pos(lock_pos), .target_reached(target_reached));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string msg);
    tick(1);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1, "read valid");
    chk(reg_rdata & m, e, msg);
  endtask : rdchk

  task automatic t_regs;
    logic [7:0]  adrs [8];
    logic [31:0] v;
    adrs = '{ADR_SWITCH_CFG, ADR_HOME_MARGIN, ADR_HALT_DECEL, ADR_COMPARE_POS,
             ADR_SOFT_LOW, ADR_SOFT_HIGH, ADR_ORIGIN_POS, ADR_CAPTURE_POS};
    foreach (adrs[i])
    begin
      v = (i == 0) ? 32'h0000_3F00 : 32'h5A00_00A0 | i;
      rdchk(adrs[i], 32'hFFFF_FFFF, RST_WORD, "reset value");
      wr(adrs[i], v);
      rdchk(adrs[i], 32'hFFFF_FFFF, v, "read back");
    end
    chk(halt_decel_rate, 32'h5A00_00A2, "decel out");
    wr(8'h7F, 32'hFFFF_FFFF);
    rdchk(8'h7F, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(ADR_SWITCH_CFG, 32'h0);
  endtask : t_regs

  task automatic t_left_hard;
    pol_l = 1'b1;
    tick(4);
    wr(ADR_SWITCH_CFG, 32'h7);
    vel = -5;
    act_l = 1'b1;
    tick(2);
    chk({31'h0, halt_hard}, 32'h0, "early halt");
    tick(1);
    chk({31'h0, halt_hard}, 32'h1, "synced halt");
    vel = 5;
    tick(2);
    chk({31'h0, halt_hard}, 32'h0, "halt away");
    rdchk(ADR_STATUS, 32'h3, 32'h1, "left status");
    vel = -5;
    tick(2);
    chk({30'h0, halt_hard, halt_soft}, 32'h2, "hard halt");
    vel = 0;
    tick(2);
    chk({30'h0, lock_neg, lock_pos}, 32'h2, "lock neg");
    rdchk(ADR_EVENTS, 32'h3, 32'h1, "left event");
    rdchk(ADR_EVENTS, 32'h3, 32'h1, "event kept");
    act_l = 1'b0;
    tick(5);
    rdchk(ADR_STATUS, 32'h3, 32'h0, "status off");
    chk({31'h0, lock_neg}, 32'h1, "lock kept");
    rdchk(ADR_EVENTS, 32'h3, 32'h1, "event last");
    tick(1);
    chk({31'h0, lock_neg}, 32'h0, "lock freed");
    rdchk(ADR_EVENTS, 32'h3, 32'h0, "event gone");
  endtask : t_left_hard

  task automatic t_right_soft;
    wr(ADR_HALT_DECEL, 32'h0001_0000);
    wr(ADR_SWITCH_CFG, 32'h27);
    vel = 5;
    act_r = 1'b1;
    tick(5);
    chk({30'h0, halt_hard, halt_soft}, 32'h1, "soft halt");
    chk(halt_decel_rate, 32'h0001_0000, "soft rate");
    vel = 0;
    tick(2);
    chk({30'h0, lock_neg, lock_pos}, 32'h1, "lock pos");
    act_r = 1'b0;
    tick(5);
    rdchk(ADR_EVENTS, 32'h3, 32'h2, "right event");
    tick(1);
    chk({31'h0, lock_pos}, 32'h0, "pos freed");
  endtask : t_right_soft

  task automatic t_swap;
    wr(ADR_SWITCH_CFG, 32'h0);
    pol_r = 1'b1;
    tick(4);
    wr(ADR_SWITCH_CFG, 32'h1D);
    vel = -5;
    act_r = 1'b1;
    tick(5);
    chk({31'h0, halt_hard}, 32'h1, "swap halt");
    rdchk(ADR_STATUS, 32'h3, 32'h1, "swap left");
    act_r = 1'b0;
    act_l = 1'b1;
    tick(5);
    rdchk(ADR_STATUS, 32'h3, 32'h0, "swap right off");
    act_l = 1'b0;
    wr(ADR_SWITCH_CFG, 32'h0);
    rdchk(ADR_EVENTS, 32'h3, 32'h1, "swap event");
  endtask : t_swap

  task automatic t_capture;
    pol_l = 1'b0;
    tick(4);
    wr(ADR_SWITCH_CFG, 32'h800);
    pos = 32'h1234_5678;
    act_l = 1'b1;
    tick(5);
    rdchk(ADR_CAPTURE_POS, 32'hFFFF_FFFF, 32'h1234_5678, "left active");
    rdchk(ADR_EVENTS, 32'h10, 32'h10, "capture done");
    pos = 32'h0000_0042;
    act_l = 1'b0;
    tick(5);
    rdchk(ADR_CAPTURE_POS, 32'hFFFF_FFFF, 32'h1234_5678, "no capture");
    act_r = 1'b1;
    tick(4);
    wr(ADR_SWITCH_CFG, 32'h1008);
    pos = -7;
    act_r = 1'b0;
    tick(5);
    rdchk(ADR_CAPTURE_POS, 32'hFFFF_FFFF, 32'hFFFF_FFF9, "right inactive");
    wr(ADR_SWITCH_CFG, 32'h0);
  endtask : t_capture

  task automatic t_virt;
    int          p [5];
    logic [31:0] e [5];
    p = '{-101, -100, 0, 99, 100};
    e = '{32'h4, 32'h4, 32'h0, 32'h0, 32'h8};
    wr(ADR_SOFT_LOW, -100);
    wr(ADR_SOFT_HIGH, 100);
    wr(ADR_SWITCH_CFG, 32'h1C0);
    foreach (p[i])
    begin
      pos = p[i];
      tick(3);
      rdchk(ADR_STATUS, 32'hC, e[i], "virtual");
    end
    vel = 5;
    tick(2);
    chk({30'h0, halt_hard, halt_soft}, 32'h2, "virtual hard");
    wr(ADR_SWITCH_CFG, 32'h2C0);
    tick(1);
    chk({30'h0, halt_hard, halt_soft}, 32'h1, "virtual linear");
    goal = pos;
    tick(3);
    chk({31'h0, target_reached}, 32'h1, "target");
    rdchk(ADR_STATUS, 32'h10, 32'h10, "target flag");
    goal = pos + 1;
    tick(3);
    chk({31'h0, target_reached}, 32'h0, "target off");
  endtask : t_virt

  initial
  begin
    {rst_n, act_l, act_r, pol_l, pol_r, reg_wr, reg_rd} = '0;
    {vel, pos, reg_addr, reg_wdata, num_errors, n_compared, cycles} = '0;
    goal = 32'h7FFF_FFFF;
    repeat (12) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    t_regs();
    t_left_hard();
    t_right_soft();
    t_swap();
    t_capture();
    t_virt();
    report_and_stop();
  end
endmodule : tb
